// ---- verilog/stop_mode_pkg.sv ----
// Package of constants and types for the software stop mode controller
`default_nettype none
package stop_mode_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] power_save_control_addr = 4'h0;
    localparam logic [3:0] stop_status_addr = 4'h4;
    localparam logic [3:0] stab_count_addr = 4'h8;
    // Power save control fields
    localparam int stop_bit_pos = 0;
    localparam int clock_source_select_pos = 1;
    localparam int stab_select_pos = 2;
    localparam logic [7:0] power_save_control_reset = 8'h00;
    // Status fields
    localparam int stat_stopped_pos = 0;
    localparam int stat_stabilising_pos = 1;
    localparam int stat_nmi_pending_pos = 2;
    localparam int stat_in_nmi_pos = 3;
    // ****************************************
    // Timing
    // ****************************************
    localparam int clk_rate_hz = 20000000;
    localparam int stab_shift_short = 8;
    localparam int stab_shift_long = 9;
    localparam logic [11:0] stab_count_reset = 12'h000;
    // Sequencer states
    typedef enum logic [3:0] {
        st_run = 4'b0001,
        st_stop = 4'b0010,
        st_wait_inactive = 4'b0100,
        st_stabilise = 4'b1000
    } stop_state_t;
endpackage
`default_nettype wire

// ---- verilog/stop_ctrl_if.sv ----
// Interface between the sequencer and the stabilisation counter
`default_nettype none
interface stop_ctrl_if;
    logic start;
    logic long_sel;
    logic done;
    logic [11:0] count;
    modport seq (output start, output long_sel, input done, input count);
    modport cnt (input start, input long_sel, output done, output count);
endinterface
`default_nettype wire

// ---- verilog/stabilisation_counter.sv ----
// Oscillation stabilisation counter, runs for 2^shift cycles once started
`default_nettype none
module stabilisation_counter #(
    parameter int shift_short = stop_mode_pkg::stab_shift_short,
    parameter int shift_long = stop_mode_pkg::stab_shift_long
) (
    input wire logic sys_clk,
    input wire logic reset,
    stop_ctrl_if.cnt ctl
);
    logic [11:0] cnt_q;
    logic run_q;
    logic [11:0] limit;

    // Terminal count picked by the select bit
    assign limit = ctl.long_sel ? 12'((1 << shift_long) - 1) : 12'((1 << shift_short) - 1);
    assign ctl.count = cnt_q;
    assign ctl.done = run_q && (cnt_q == limit);

    // Counting process
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= stop_mode_pkg::stab_count_reset;
            run_q <= 1'b0;
        end else if (ctl.start) begin
            cnt_q <= 12'h000;
            run_q <= 1'b1;
        end else if (ctl.done) begin
            run_q <= 1'b0;
        end else if (run_q) begin
            cnt_q <= cnt_q + 12'h001;
        end
    end

    a_count_bounded: assert property (@(posedge sys_clk) disable iff (reset)
        run_q |-> cnt_q <= limit)
        else $error("stabilisation count overran its limit");
endmodule
`default_nettype wire

// ---- verilog/software_stop_mode_control.sv ----
// Software stop mode sequencer with pin hold logic and register port
//
// The strobed register port and the address map were left to the implementer.
`default_nettype none
module software_stop_mode_control #(
    parameter int shift_short = stop_mode_pkg::stab_shift_short,
    parameter int shift_long = stop_mode_pkg::stab_shift_long
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire logic nmi_pin,
    input wire logic nmi_falling_valid,
    input wire logic direct_clock_pin,
    input wire logic nmi_service_active,
    input wire logic nmi_ack,
    input wire logic ext_bus_enable,
    input wire logic bus_drive_oe_n_in,
    input wire logic [1:0] byte_write_strobes_in,
    input wire logic io_read_strobe_in,
    input wire logic io_write_strobe_in,
    input wire logic [7:0] chip_selects_in,
    input wire logic clock_output_in,
    output logic osc_enable,
    output logic pll_enable,
    output logic sys_clock_enable,
    output logic cpu_run,
    output logic periph_enable,
    output logic nmi_request,
    output logic bus_drive_oe_n,
    output logic [1:0] byte_write_strobes,
    output logic io_read_strobe,
    output logic io_write_strobe,
    output logic [7:0] chip_selects,
    output logic clock_output_pin,
    output logic dram_enable,
    output logic hold_ack_oe_n,
    output logic hold_sample_enable
);
    stop_mode_pkg::stop_state_t state_q;
    stop_mode_pkg::stop_state_t state_d;
    logic [7:0] power_save_control_q;
    logic nmi_prev_q;
    logic nmi_pending_q;
    logic stop_in_nmi_q;
    logic stop_req;
    logic nmi_valid_edge;
    logic nmi_inactive_edge;
    logic stopped;

    stop_ctrl_if ctl ();

    stabilisation_counter #(
        .shift_short(shift_short),
        .shift_long(shift_long)
    ) u_counter (
        .sys_clk(sys_clk),
        .reset(reset),
        .ctl(ctl)
    );

    // Edge detection on the NMI pin, polarity chosen by input
    function automatic logic is_active(input logic lvl, input logic fall_valid);
        is_active = fall_valid ? ~lvl : lvl;
    endfunction

    assign nmi_valid_edge = is_active(nmi_pin, nmi_falling_valid) && !nmi_prev_q;
    assign nmi_inactive_edge = !is_active(nmi_pin, nmi_falling_valid) && nmi_prev_q;
    assign stop_req = reg_write && (reg_addr == stop_mode_pkg::power_save_control_addr)
        && reg_wdata[stop_mode_pkg::stop_bit_pos];
    assign stopped = (state_q != stop_mode_pkg::st_run);

    // ****************************************
    // Register port
    // ****************************************
    // Power save control; stop bit self clears on wake
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            power_save_control_q <= stop_mode_pkg::power_save_control_reset;
        end else if (reg_write && reg_addr == stop_mode_pkg::power_save_control_addr) begin
            power_save_control_q <= reg_wdata;
        end else if (stopped && state_d == stop_mode_pkg::st_run) begin
            // Cleared on every way back to run, with or without a count
            power_save_control_q[stop_mode_pkg::stop_bit_pos] <= 1'b0;
        end
    end

    // Read data one cycle after the strobe; unmapped reads as zero
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            case (reg_addr)
                stop_mode_pkg::power_save_control_addr:
                    reg_rdata <= {8'h00, power_save_control_q};
                stop_mode_pkg::stop_status_addr: reg_rdata <= {12'h000, stop_in_nmi_q,
                    nmi_pending_q, state_q == stop_mode_pkg::st_stabilise, stopped};
                stop_mode_pkg::stab_count_addr: reg_rdata <= {4'h0, ctl.count};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    // Next state; leaving stop only by NMI edge, reset is asynchronous
    always_comb begin
        state_d = state_q;
        case (state_q)
            stop_mode_pkg::st_run: begin
                if (stop_req) begin
                    state_d = stop_mode_pkg::st_stop;
                end
            end
            stop_mode_pkg::st_stop: begin
                if (nmi_valid_edge) begin
                    state_d = stop_mode_pkg::st_wait_inactive;
                end
            end
            stop_mode_pkg::st_wait_inactive: begin
                if (nmi_inactive_edge) begin
                    state_d = power_save_control_q[stop_mode_pkg::clock_source_select_pos]
                        ? stop_mode_pkg::st_run : stop_mode_pkg::st_stabilise;
                end
            end
            stop_mode_pkg::st_stabilise: begin
                if (ctl.done) begin
                    state_d = stop_mode_pkg::st_run;
                end
            end
            default: state_d = stop_mode_pkg::st_run;
        endcase
    end

    // State register; reset pin release is an ordinary reset
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= stop_mode_pkg::st_run;
        end else begin
            state_q <= state_d;
        end
    end

    // Counter start at the inactive edge
    assign ctl.start = (state_q == stop_mode_pkg::st_wait_inactive) && nmi_inactive_edge
        && !power_save_control_q[stop_mode_pkg::clock_source_select_pos];
    assign ctl.long_sel = power_save_control_q[stop_mode_pkg::stab_select_pos];

    // NMI pin history as active level, resets inactive so no false edge
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            nmi_prev_q <= 1'b0;
        end else begin
            nmi_prev_q <= is_active(nmi_pin, nmi_falling_valid);
        end
    end

    // Remember whether stop was entered inside NMI servicing
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stop_in_nmi_q <= 1'b0;
        end else if (state_q == stop_mode_pkg::st_run && stop_req) begin
            stop_in_nmi_q <= nmi_service_active;
        end
    end

    // Pending NMI: set on any valid edge, set wins over acknowledge
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            nmi_pending_q <= 1'b0;
        end else if (nmi_valid_edge) begin
            nmi_pending_q <= 1'b1;
        end else if (nmi_ack) begin
            nmi_pending_q <= 1'b0;
        end
    end

    // Request to the CPU on the single NMI vector, held back while stopped
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            nmi_request <= 1'b0;
        end else begin
            nmi_request <= nmi_pending_q && !stopped && !nmi_ack
                && !(stop_in_nmi_q && nmi_service_active);
        end
    end

    // ****************************************
    // Clock and core enables
    // ****************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            osc_enable <= 1'b1;
            pll_enable <= 1'b1;
            sys_clock_enable <= 1'b1;
            cpu_run <= 1'b1;
            periph_enable <= 1'b1;
        end else begin
            osc_enable <= (state_d != stop_mode_pkg::st_stop);
            pll_enable <= (state_d != stop_mode_pkg::st_stop);
            sys_clock_enable <= (state_d == stop_mode_pkg::st_run);
            cpu_run <= (state_d == stop_mode_pkg::st_run);
            periph_enable <= (state_d == stop_mode_pkg::st_run);
        end
    end

    // ****************************************
    // External bus pin states
    // ****************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bus_drive_oe_n <= 1'b1;
            byte_write_strobes <= 2'h3;
            io_read_strobe <= 1'b1;
            io_write_strobe <= 1'b1;
            chip_selects <= 8'hff;
            clock_output_pin <= 1'b0;
            dram_enable <= 1'b1;
            hold_ack_oe_n <= 1'b1;
            hold_sample_enable <= 1'b1;
        end else if (ext_bus_enable && state_d != stop_mode_pkg::st_run) begin
            bus_drive_oe_n <= 1'b1;
            byte_write_strobes <= 2'h3;
            io_read_strobe <= 1'b1;
            io_write_strobe <= 1'b1;
            chip_selects <= 8'hff;
            clock_output_pin <= 1'b0;
            dram_enable <= 1'b1;
            hold_ack_oe_n <= 1'b1;
            hold_sample_enable <= 1'b0;
        end else begin
            bus_drive_oe_n <= bus_drive_oe_n_in;
            byte_write_strobes <= byte_write_strobes_in;
            io_read_strobe <= io_read_strobe_in;
            io_write_strobe <= io_write_strobe_in;
            chip_selects <= chip_selects_in;
            clock_output_pin <= stopped ? 1'b0 : clock_output_in;
            dram_enable <= 1'b1;
            hold_ack_oe_n <= 1'b0;
            hold_sample_enable <= !stopped;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_stop_clocks_off: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == stop_mode_pkg::st_stop |-> !osc_enable && !pll_enable)
        else $error("clock generator running in stop");
    a_stop_entry: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == stop_mode_pkg::st_run && stop_req |=> state_q == stop_mode_pkg::st_stop
        && !cpu_run)
        else $error("stop write did not enter stop");
    a_stab_wait: assert property (@(posedge sys_clk) disable iff (reset)
        ctl.start |=> (state_q == stop_mode_pkg::st_stabilise && !cpu_run) [*4])
        else $error("resumed before stabilisation");
    a_cpu_halted: assert property (@(posedge sys_clk) disable iff (reset)
        stopped |-> !cpu_run && !periph_enable)
        else $error("core active while stopped");
    a_periph_stop: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(stopped) |-> !periph_enable && !sys_clock_enable)
        else $error("peripherals not stopped");
    a_bus_pins: assert property (@(posedge sys_clk) disable iff (reset)
        ext_bus_enable && $past(ext_bus_enable) && $past(state_d) == stop_mode_pkg::st_stop
        |-> bus_drive_oe_n && chip_selects == 8'hff && !clock_output_pin)
        else $error("bus pins wrong in stop");
    a_wake_source: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == stop_mode_pkg::st_stop && !nmi_valid_edge
        |=> state_q == stop_mode_pkg::st_stop)
        else $error("stop left without NMI");
    a_nmi_raised: assert property (@(posedge sys_clk) disable iff (reset)
        nmi_pending_q && !stopped && !nmi_ack && !nmi_service_active |=> nmi_request)
        else $error("waking NMI not raised");
    a_nmi_nested: assert property (@(posedge sys_clk) disable iff (reset)
        stop_in_nmi_q && nmi_service_active |=> !nmi_request)
        else $error("nested NMI accepted");
    a_count_then_run: assert property (@(posedge sys_clk) disable iff (reset)
        state_q == stop_mode_pkg::st_stabilise && ctl.done |=> cpu_run)
        else $error("no resume after count");
endmodule
`default_nettype wire

// ---- dv/test_software_stop_mode_control.sv ----
// Self-checking bench for the software stop mode controller
`default_nettype none
module test_software_stop_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Signals and instance
    // ****************************************
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic nmi_pin = 1'b1;
    logic nmi_falling_valid = 1'b1;
    logic direct_clock_pin = 1'b0;
    logic nmi_service_active = 1'b0;
    logic nmi_ack = 1'b0;
    logic ext_bus_enable = 1'b1;
    logic bus_drive_oe_n_in = 1'b0;
    logic [1:0] byte_write_strobes_in = 2'h1;
    logic io_read_strobe_in = 1'b0;
    logic io_write_strobe_in = 1'b0;
    logic [7:0] chip_selects_in = 8'h5a;
    logic clock_output_in = 1'b1;
    logic osc_enable, pll_enable, sys_clock_enable, cpu_run, periph_enable, nmi_request;
    logic bus_drive_oe_n, io_read_strobe, io_write_strobe, clock_output_pin;
    logic dram_enable, hold_ack_oe_n, hold_sample_enable;
    logic [1:0] byte_write_strobes;
    logic [7:0] chip_selects;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    software_stop_mode_control #(.shift_short(2), .shift_long(3)) software_stop_mode_control_inst (
        .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .nmi_pin(nmi_pin), .nmi_falling_valid(nmi_falling_valid),
        .direct_clock_pin(direct_clock_pin), .nmi_service_active(nmi_service_active),
        .nmi_ack(nmi_ack), .ext_bus_enable(ext_bus_enable),
        .bus_drive_oe_n_in(bus_drive_oe_n_in), .byte_write_strobes_in(byte_write_strobes_in),
        .io_read_strobe_in(io_read_strobe_in), .io_write_strobe_in(io_write_strobe_in),
        .chip_selects_in(chip_selects_in), .clock_output_in(clock_output_in),
        .osc_enable(osc_enable), .pll_enable(pll_enable), .sys_clock_enable(sys_clock_enable),
        .cpu_run(cpu_run), .periph_enable(periph_enable), .nmi_request(nmi_request),
        .bus_drive_oe_n(bus_drive_oe_n), .byte_write_strobes(byte_write_strobes),
        .io_read_strobe(io_read_strobe), .io_write_strobe(io_write_strobe),
        .chip_selects(chip_selects), .clock_output_pin(clock_output_pin),
        .dram_enable(dram_enable), .hold_ack_oe_n(hold_ack_oe_n),
        .hold_sample_enable(hold_sample_enable)
    );
    // Clock at 50 ns period
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic pulse_ack();
        @(posedge sys_clk);
        nmi_ack <= 1'b1;
        @(posedge sys_clk);
        nmi_ack <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    // Active edge, short active level, inactive edge, then count cycles to run
    task automatic wake(output int n);
        @(posedge sys_clk);
        nmi_pin <= !nmi_falling_valid;
        repeat (3) @(posedge sys_clk);
        #1 check("osc_back", {osc_enable, pll_enable}, 16'h0003);
        check("cpu_held_low", cpu_run, 16'h0000);
        @(posedge sys_clk);
        nmi_pin <= nmi_falling_valid;
        n = 0;
        while (cpu_run !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            #1 n++;
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    // Run state, passthrough, register read-back and unmapped read
    task automatic run_state();
        logic [15:0] d;
        check("cpu_run", cpu_run, 16'h0001);
        check("chip_selects", chip_selects, 16'h005a);
        check("oe_n", bus_drive_oe_n, 16'h0000);
        check("clk_out", clock_output_pin, 16'h0001);
        check("nmi_req", nmi_request, 16'h0000);
        rd(stop_mode_pkg::power_save_control_addr, d);
        check("ctl_reset", d, 16'h0000);
        rd(4'hc, d);
        check("unmapped", d, 16'h0000);
        wr(stop_mode_pkg::power_save_control_addr, 8'h02);
        repeat (2) @(posedge sys_clk);
        #1 check("no_stop", cpu_run, 16'h0001);
    endtask
    // Stop entry, pin state while stopped, wake timing by setting
    task automatic stop_case(input logic [7:0] ctl_val, input int lo, input int hi);
        logic [15:0] d;
        int n;
        wr(stop_mode_pkg::power_save_control_addr, ctl_val);
        repeat (2) @(posedge sys_clk);
        #1 check("clocks_off", {osc_enable, pll_enable, sys_clock_enable}, 16'h0000);
        check("cpu_off", cpu_run, 16'h0000);
        check("periph_off", periph_enable, 16'h0000);
        check("float", {bus_drive_oe_n, hold_ack_oe_n, hold_sample_enable}, 16'h0006);
        check("strobes_high", {byte_write_strobes, io_read_strobe, io_write_strobe}, 16'h000f);
        check("cs_high", chip_selects, 16'h00ff);
        check("clk_out_low", clock_output_pin, 16'h0000);
        check("dram_on", dram_enable, 16'h0001);
        rd(stop_mode_pkg::stop_status_addr, d);
        check("stat_stopped", d[stop_mode_pkg::stat_stopped_pos], 16'h0001);
        pulse_ack();
        #1 check("ack_no_wake", cpu_run, 16'h0000);
        wake(n);
        check("count_lo", n >= lo, 16'h0001);
        check("count_hi", n <= hi, 16'h0001);
        repeat (2) @(posedge sys_clk);
        #1 check("nmi_raised", nmi_request, 16'h0001);
        pulse_ack();
        #1 check("nmi_taken", nmi_request, 16'h0000);
        rd(stop_mode_pkg::power_save_control_addr, d);
        check("stop_cleared", d[stop_mode_pkg::stop_bit_pos], 16'h0000);
    endtask
    // Stop entered inside NMI servicing leaves the request pending
    task automatic stop_in_nmi();
        logic [15:0] d;
        int n;
        @(posedge sys_clk);
        nmi_service_active <= 1'b1;
        wr(stop_mode_pkg::power_save_control_addr, 8'h01);
        repeat (2) @(posedge sys_clk);
        wake(n);
        check("woke", cpu_run, 16'h0001);
        repeat (2) @(posedge sys_clk);
        #1 check("nmi_held", nmi_request, 16'h0000);
        rd(stop_mode_pkg::stop_status_addr, d);
        check("pending", d[stop_mode_pkg::stat_nmi_pending_pos], 16'h0001);
        @(posedge sys_clk);
        nmi_service_active <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 check("nmi_later", nmi_request, 16'h0001);
        pulse_ack();
    endtask
    // Reset pin ends stop like an ordinary reset
    task automatic reset_in_stop();
        logic [15:0] d;
        wr(stop_mode_pkg::power_save_control_addr, 8'h01);
        repeat (3) @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 check("rst_run", {osc_enable, cpu_run, periph_enable}, 16'h0007);
        check("rst_oe", bus_drive_oe_n, 16'h0001);
        @(posedge sys_clk);
        reset <= 1'b0;
        rd(stop_mode_pkg::power_save_control_addr, d);
        check("rst_ctl", d, 16'h0000);
        repeat (2) @(posedge sys_clk);
        #1 check("rst_cpu", cpu_run, 16'h0001);
    endtask
    // ****************************************
    // Main sequence and timeout
    // ****************************************
    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 run_state();
        stop_case(8'h01, 4, 10);
        stop_case(8'h05, 8, 14);
        // Rising edge valid: idle low, then back to falling mode
        @(posedge sys_clk);
        nmi_falling_valid <= 1'b0;
        nmi_pin <= 1'b0;
        stop_case(8'h01, 4, 10);
        @(posedge sys_clk);
        nmi_falling_valid <= 1'b1;
        nmi_pin <= 1'b1;
        stop_in_nmi();
        reset_in_stop();
        summarize();
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
endmodule
`default_nettype wire
